// file: pkg/exec_pkg.sv
// constants and types for the logic, bit-clear and branch-on-carry executor
package exec_pkg;
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_INSTR     = 8'h04;
	localparam logic [7:0] ADDR_ACC       = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0c;
	localparam logic [7:0] ADDR_BANK      = 8'h10;
	localparam logic [7:0] ADDR_PC        = 8'h14;
	localparam logic [7:0] ADDR_INDEX     = 8'h18;
	localparam logic [7:0] ADDR_FILE_IDX  = 8'h1c;
	localparam logic [7:0] ADDR_FILE_DATA = 8'h20;
	localparam logic [7:0] ADDR_STATE     = 8'h24;
	localparam int         EXT_BIT        = 0;
	localparam int         C_BIT          = 0;
	localparam int         DC_BIT         = 1;
	localparam int         Z_BIT          = 2;
	localparam int         OV_BIT         = 3;
	localparam int         N_BIT          = 4;
	localparam int         BUSY_BIT       = 0;
	localparam int         UNK_BIT        = 1;
	localparam int         LAST_LSB       = 16;
	localparam logic [7:0] OPC_AND_LIT    = 8'h0b;
	localparam logic [5:0] OPC_AND_FILE   = 6'h05;
	localparam logic [5:0] OPC_ADD_CARRY  = 6'h08;
	localparam logic [3:0] OPC_BIT_CLEAR  = 4'h9;
	localparam logic [7:0] OPC_BR_CARRY   = 8'he2;
	localparam logic [7:0] INDEX_LIMIT    = 8'h5f;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [20:0] PC_STEP       = 21'h00_0002;
	localparam int         FILE_DEPTH     = 16;
	localparam int         FILE_AW        = 4;
	localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_Q1   = 5'b00010,
		ST_Q2   = 5'b00100,
		ST_Q3   = 5'b01000,
		ST_Q4   = 5'b10000
	} state_type;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_AND_LIT,
		OP_AND_FILE,
		OP_ADD_CARRY,
		OP_BIT_CLEAR,
		OP_BR_CARRY
	} op_type;

	typedef struct packed {
		logic               we;
		logic [FILE_AW-1:0] addr;
		logic [7:0]         data;
	} file_wr_type;
endpackage

// file: hw/file_store.sv
// general purpose file storage, one write port and two read ports
`timescale 1ns/1ps
module file_store
	import exec_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire file_wr_type        wr,
	input  wire logic [FILE_AW-1:0] rd_addr_a,
	input  wire logic [FILE_AW-1:0] rd_addr_b,
	output logic      [7:0]         rd_data_a,
	output logic      [7:0]         rd_data_b
);
	logic [7:0] mem [FILE_DEPTH];

	genvar i;
	generate
		for (i = 0; i < FILE_DEPTH; i++) begin : g_entry
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mem[i] <= 8'h00;
				end else if (wr.we && wr.addr == FILE_AW'(i)) begin
					mem[i] <= wr.data;
				end
			end
		end
	endgenerate

	assign rd_data_a = mem[rd_addr_a];
	assign rd_data_b = mem[rd_addr_b];
endmodule

// file: hw/logic_and_branch_instr_exec.sv
// executor for and, add-with-carry, bit clear and branch-on-carry, apb registers
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module logic_and_branch_instr_exec
	import exec_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             busy,
	output logic      [3:0]  phase
);
	state_type   state;
	state_type   next_state;
	op_type      op;
	logic [15:0] ir;
	logic        nop_cycle;
	logic        ext_enable;
	logic [7:0]  acc;
	logic [4:0]  status;
	logic [3:0]  bank_select_register;
	logic [20:0] program_counter;
	logic [11:0] index_base;
	logic [FILE_AW-1:0] file_idx;
	logic        unknown_op;
	logic [11:0] eff_addr;
	logic [11:0] last_addr;
	logic [7:0]  operand;
	logic [8:0]  result;
	logic [4:0]  next_status;
	logic [7:0]  file_rd;
	logic [7:0]  file_apb_rd;
	logic [31:0] rd_mux;
	logic        mapped;
	logic        setup;
	logic        wr_en;
	logic        taken;
	logic        byte_op;
	logic [20:0] br_offset;
	file_wr_type core_wr;
	file_wr_type fw;

	// apb slave: ready in the first access cycle, so every transfer is two cycles
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite & ~pslverr;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_STATE);

	always_comb begin
		unique case (paddr)
			ADDR_CTRL:      rd_mux = {31'h0000_0000, ext_enable};
			ADDR_INSTR:     rd_mux = {16'h0000, ir};
			ADDR_ACC:       rd_mux = {24'h00_0000, acc};
			ADDR_STATUS:    rd_mux = {27'h000_0000, status};
			ADDR_BANK:      rd_mux = {28'h000_0000, bank_select_register};
			ADDR_PC:        rd_mux = {11'h000, program_counter};
			ADDR_INDEX:     rd_mux = {20'h0_0000, index_base};
			ADDR_FILE_IDX:  rd_mux = {28'h000_0000, file_idx};
			ADDR_FILE_DATA: rd_mux = {24'h00_0000, file_apb_rd};
			ADDR_STATE:     rd_mux = {4'h0, last_addr, 14'h0000, unknown_op, busy};
			default:        rd_mux = RESET_WORD;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RESET_WORD;
		end else begin
			pready  <= setup;
			// writes while an instruction runs are refused so core and bus never collide
			pslverr <= setup & (~mapped | (pwrite & busy));
			if (setup) begin
				prdata <= mapped ? rd_mux : RESET_WORD;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_enable <= 1'b0;
			bank_select_register <= 4'h0;
			index_base <= 12'h000;
			file_idx <= '0;
		end else if (wr_en) begin
			unique case (paddr)
				ADDR_CTRL:     ext_enable <= pwdata[EXT_BIT];
				ADDR_BANK:     bank_select_register <= pwdata[3:0];
				ADDR_INDEX:    index_base <= pwdata[11:0];
				ADDR_FILE_IDX: file_idx <= pwdata[FILE_AW-1:0];
				default:       ;
			endcase
		end
	end

	// decode of the latched instruction word
	always_comb begin
		if (ir[15:8] == OPC_AND_LIT) begin
			op = OP_AND_LIT;
		end else if (ir[15:10] == OPC_AND_FILE) begin
			op = OP_AND_FILE;
		end else if (ir[15:10] == OPC_ADD_CARRY) begin
			op = OP_ADD_CARRY;
		end else if (ir[15:12] == OPC_BIT_CLEAR) begin
			op = OP_BIT_CLEAR;
		end else if (ir[15:8] == OPC_BR_CARRY) begin
			op = OP_BR_CARRY;
		end else begin
			op = OP_NONE;
		end
	end

	assign byte_op = (op == OP_AND_FILE) || (op == OP_ADD_CARRY);

	// file address formation
	always_comb begin
		if (ir[8]) begin
			eff_addr = {bank_select_register, ir[7:0]};
		end else if (ext_enable && ir[7:0] <= INDEX_LIMIT) begin
			eff_addr = index_base + {4'h0, ir[7:0]};
		end else if (ir[7:0] <= INDEX_LIMIT) begin
			eff_addr = {4'h0, ir[7:0]};
		end else begin
			eff_addr = {ACCESS_HI_BANK, ir[7:0]};
		end
	end

	// signed operand doubled into a byte offset
	assign br_offset = {{12{ir[7]}}, ir[7:0], 1'b0};
	assign taken = (op == OP_BR_CARRY) && status[C_BIT];

	// phase sequencer
	always_comb begin
		unique case (state)
			ST_IDLE: next_state = (wr_en && paddr == ADDR_INSTR) ? ST_Q1 : ST_IDLE;
			ST_Q1:   next_state = ST_Q2;
			ST_Q2:   next_state = ST_Q3;
			ST_Q3:   next_state = ST_Q4;
			ST_Q4:   next_state = (taken && !nop_cycle) ? ST_Q1 : ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			busy <= 1'b0;
			nop_cycle <= 1'b0;
		end else begin
			state <= next_state;
			busy <= next_state != ST_IDLE;
			if (state == ST_Q4) begin
				nop_cycle <= taken && !nop_cycle;
			end
		end
	end

	assign phase = state[4:1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir <= 16'h0000;
		end else if (wr_en && paddr == ADDR_INSTR) begin
			ir <= pwdata[15:0];
		end
	end

	// read operand in the second phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			operand <= 8'h00;
			last_addr <= 12'h000;
		end else if (state == ST_Q2 && !nop_cycle) begin
			operand <= (op == OP_AND_LIT) ? ir[7:0] : file_rd;
			last_addr <= eff_addr;
		end
	end

	// compute in the third phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= 9'h000;
		end else if (state == ST_Q3 && !nop_cycle) begin
			unique case (op)
				OP_AND_LIT, OP_AND_FILE: result <= {1'b0, acc & operand};
				OP_ADD_CARRY: result <= {1'b0, acc} + {1'b0, operand}
					+ {8'h00, status[C_BIT]};
				OP_BIT_CLEAR: result <= {1'b0, operand & ~(8'h01 << ir[11:9])};
				default: result <= 9'h000;
			endcase
		end
	end

	// flags: branch and bit clear leave them alone
	always_comb begin
		next_status = status;
		if (op == OP_AND_LIT || op == OP_AND_FILE) begin
			next_status[N_BIT] = result[7];
			next_status[Z_BIT] = result[7:0] == 8'h00;
		end else if (op == OP_ADD_CARRY) begin
			next_status[N_BIT] = result[7];
			next_status[Z_BIT] = result[7:0] == 8'h00;
			next_status[C_BIT] = result[8];
			// carry into bit four is the carry out of the low nibble
			next_status[DC_BIT] = result[4] ^ acc[4] ^ operand[4];
			next_status[OV_BIT] = (acc[7] == operand[7]) && (result[7] != acc[7]);
		end
	end

	// write destination in the fourth phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= 8'h00;
			status <= 5'h00;
		end else if (state == ST_Q4 && !nop_cycle) begin
			status <= next_status;
			if (op == OP_AND_LIT || (byte_op && !ir[9])) begin
				acc <= result[7:0];
			end
		end else if (wr_en && paddr == ADDR_ACC) begin
			acc <= pwdata[7:0];
		end else if (wr_en && paddr == ADDR_STATUS) begin
			status <= pwdata[4:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_counter <= 21'h00_0000;
			unknown_op <= 1'b0;
		end else if (state == ST_Q4 && !nop_cycle) begin
			unknown_op <= op == OP_NONE;
			// the fetch has already moved on by one word, hence the step of two
			program_counter <= taken ? program_counter + PC_STEP + br_offset
				: program_counter + PC_STEP;
		end else if (wr_en && paddr == ADDR_PC) begin
			program_counter <= pwdata[20:0];
		end
	end

	// the core write takes the port; bus writes are refused while busy anyway
	always_comb begin
		core_wr.we = state == ST_Q4 && !nop_cycle
			&& ((byte_op && ir[9]) || op == OP_BIT_CLEAR);
		core_wr.addr = eff_addr[FILE_AW-1:0];
		core_wr.data = result[7:0];
		if (core_wr.we) begin
			fw = core_wr;
		end else begin
			fw.we = wr_en && paddr == ADDR_FILE_DATA;
			fw.addr = file_idx;
			fw.data = pwdata[7:0];
		end
	end

	// only the low address bits index the small store, so banks alias
	file_store u_file (
		.pclk      (pclk),
		.presetn   (presetn),
		.wr        (fw),
		.rd_addr_a (eff_addr[FILE_AW-1:0]),
		.rd_addr_b (file_idx),
		.rd_data_a (file_rd),
		.rd_data_b (file_apb_rd)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_and_lit_acc: assert property (
		(state == ST_Q3 && op == OP_AND_LIT && !nop_cycle)
		|-> ##2 acc == ($past(acc, 2) & $past(ir[7:0], 2)))
		else $error("and literal result wrong");

	a_and_file_flags: assert property (
		(state == ST_Q4 && op == OP_AND_FILE && !nop_cycle)
		|=> status[Z_BIT] == ($past(result[7:0]) == 8'h00)
		&& status[C_BIT] == $past(status[C_BIT])
		&& status[OV_BIT] == $past(status[OV_BIT]))
		else $error("and file flags wrong");

	a_dest_select: assert property (
		(state == ST_Q4 && byte_op && !nop_cycle)
		|-> core_wr.we == ir[9] ##1 (ir[9] || acc == $past(result[7:0])))
		else $error("destination select wrong");

	a_bank_addr: assert property (
		(busy && ir[8]) |-> eff_addr == {bank_select_register, ir[7:0]})
		else $error("banked address wrong");

	a_indexed_addr: assert property (
		(busy && !ir[8] && ext_enable && ir[7:0] <= INDEX_LIMIT)
		|-> eff_addr == index_base + {4'h0, ir[7:0]})
		else $error("indexed address wrong");

	a_bit_clear: assert property (
		(state == ST_Q4 && op == OP_BIT_CLEAR && !nop_cycle)
		|-> core_wr.data[ir[11:9]] == 1'b0 ##1 status == $past(status))
		else $error("bit clear wrong");

	a_branch_untaken: assert property (
		(state == ST_Q4 && op == OP_BR_CARRY && !status[C_BIT] && !nop_cycle)
		|=> state == ST_IDLE && program_counter == $past(program_counter) + PC_STEP)
		else $error("untaken branch wrong");

	a_branch_target: assert property (
		(state == ST_Q4 && taken && !nop_cycle)
		|=> program_counter == $past(program_counter) + PC_STEP
		+ {{12{$past(ir[7])}}, $past(ir[7:0]), 1'b0})
		else $error("branch target wrong");

	a_branch_timing: assert property (
		(state == ST_Q4 && taken && !nop_cycle)
		|=> (state == ST_Q1 && nop_cycle) ##1 state == ST_Q2 ##1 state == ST_Q3
		##1 state == ST_Q4 ##1 state == ST_IDLE)
		else $error("taken branch timing wrong");

	a_add_carry_sum: assert property (
		(state == ST_Q3 && op == OP_ADD_CARRY && !nop_cycle)
		|=> result == $past({1'b0, acc} + {1'b0, operand} + {8'h00, status[C_BIT]}))
		else $error("add with carry sum wrong");

	a_phase_order: assert property (
		(state == ST_Q1) |=> state == ST_Q2 ##1 state == ST_Q3 ##1 state == ST_Q4)
		else $error("phase order wrong");

	c_branch_taken: cover property (state == ST_Q4 && taken && !nop_cycle);
	c_branch_skip: cover property (state == ST_Q4 && op == OP_BR_CARRY && !taken);
	c_file_write: cover property (core_wr.we && op == OP_ADD_CARRY);
	c_indexed: cover property (busy && !ir[8] && ext_enable && ir[7:0] <= INDEX_LIMIT);
endmodule

// file: verification/logic_and_branch_instr_exec_tb_top.sv
// self-checking bench for the and, add-with-carry, bit clear and branch-on-carry executor
`timescale 1ns/1ps
module logic_and_branch_instr_exec_tb_top;
	import exec_pkg::*;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic [3:0]  phase;
	int          failures = 0;
	int          n_tests  = 0;
	logic [31:0] r;
	logic        e;
	logic [39:0] t;
	// acc, file, carry in, expected acc, expected status
	logic [39:0] add_tab [0:3] = '{40'h4d_0201_5002, 40'hff_0100_0007, 40'h7f_0100_801a,
		40'h08_0800_1002};
	// status, offset, expected pc, busy cycles
	logic [39:0] br_tab [0:3] = '{40'h1e_0501_0204, 40'h1f_0501_0c08, 40'h1f_8000_0208,
		40'h1f_7f02_0008};

	logic_and_branch_instr_exec dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy), .phase(phase));

	initial begin
		forever #5 pclk = ~pclk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one transfer; starts on a fresh edge so psel never changes twice in one step
	// no cycle limit on the wait: only the watchdog ends a hang
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, exp);
	endtask

	task ld(input logic [7:0] acc, input logic [7:0] st, input logic [3:0] fi,
		input logic [7:0] fd);
		wr(ADDR_ACC, {24'h00_0000, acc});
		wr(ADDR_STATUS, {24'h00_0000, st});
		wr(ADDR_FILE_IDX, {28'h000_0000, fi});
		wr(ADDR_FILE_DATA, {24'h00_0000, fd});
	endtask

	// counts busy cycles and records the phase sequence of the first instruction cycle
	task exe(input logic [15:0] ins, input int cyc);
		int n;
		logic [3:0] ph [0:7];
		wr(ADDR_INSTR, {16'h0000, ins});
		n = 0;
		for (int i = 0; i < 30; i++) begin
			#1;
			if (busy === 1'b1 && n < 8) ph[n] = phase;
			if (busy === 1'b1) n++;
			@(posedge pclk);
		end
		chk(n, cyc);
		for (int i = 0; i < 4; i++) chk(ph[i], 4'b0001 << i);
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// whole run is about twelve hundred cycles; the 30000-cycle limit leaves ample margin
	initial begin
		#300_000;
		failures++;
		test_done;
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({busy, phase}, 32'h0000_0000);
		for (int a = 0; a <= 36; a += 4) rdc(a[7:0], 32'h0000_0000);
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		chk(e, 1'b1);
		apb(1'b0, 8'h02, 32'h0000_0000);
		chk(e, 1'b1);
		$display("test reset done");

		ld(8'ha3, 8'h0b, 4'h0, 8'h00);
		exe(16'h0b5f, 4);
		rdc(ADDR_ACC, 32'h0000_0003);
		rdc(ADDR_STATUS, 32'h0000_000b);
		exe(16'h0b00, 4);
		rdc(ADDR_ACC, 32'h0000_0000);
		rdc(ADDR_STATUS, 32'h0000_000f);
		wr(ADDR_ACC, 32'h0000_0080);
		exe(16'h0bf0, 4);
		rdc(ADDR_ACC, 32'h0000_0080);
		rdc(ADDR_STATUS, 32'h0000_001b);
		$display("test and literal done");

		wr(ADDR_BANK, 32'h0000_0003);
		ld(8'h17, 8'h1b, 4'h5, 8'hc2);
		exe(16'h1525, 4);
		rdc(ADDR_ACC, 32'h0000_0002);
		rdc(ADDR_STATUS, 32'h0000_000b);
		rdc(ADDR_FILE_DATA, 32'h0000_00c2);
		rdc(ADDR_STATE, 32'h0325_0000);
		ld(8'hf5, 8'h00, 4'h0, 8'h0f);
		exe(16'h1680, 4);
		rdc(ADDR_FILE_DATA, 32'h0000_0005);
		rdc(ADDR_ACC, 32'h0000_00f5);
		rdc(ADDR_STATE, 32'h0f80_0000);
		// boundary of the indexed range: 0x5f indexed, 0x60 falls back to the access bank
		wr(ADDR_CTRL, 32'h0000_0001);
		wr(ADDR_INDEX, 32'h0000_0100);
		exe(16'h165f, 4);
		rdc(ADDR_STATE, 32'h015f_0000);
		exe(16'h1660, 4);
		rdc(ADDR_STATE, 32'h0f60_0000);
		wr(ADDR_CTRL, 32'h0000_0000);
		$display("test and file done");

		ld(8'h00, 8'h1f, 4'h2, 8'h00);
		for (int b = 0; b < 8; b++) begin
			wr(ADDR_FILE_DATA, 32'h0000_00ff);
			exe({4'h9, b[2:0], 1'b1, 8'h22}, 4);
			rdc(ADDR_FILE_DATA, {24'h00_0000, ~(8'h01 << b)});
		end
		rdc(ADDR_STATUS, 32'h0000_001f);
		$display("test bit clear done");

		for (int i = 0; i < 4; i++) begin
			t = add_tab[i];
			ld(t[39:32], t[23:16], 4'h5, t[31:24]);
			exe(16'h2125, 4);
			rdc(ADDR_ACC, {24'h00_0000, t[15:8]});
			rdc(ADDR_STATUS, {24'h00_0000, t[7:0]});
		end
		$display("test add with carry done");

		for (int i = 0; i < 4; i++) begin
			t = br_tab[i];
			wr(ADDR_PC, 32'h0000_0100);
			wr(ADDR_STATUS, {24'h00_0000, t[39:32]});
			exe({8'he2, t[31:24]}, int'(t[7:0]));
			rdc(ADDR_PC, {16'h0000, t[23:8]});
			rdc(ADDR_STATUS, {24'h00_0000, t[39:32]});
		end
		$display("test branch done");

		// a write landing in the nop cycle of a taken branch must be refused
		wr(ADDR_PC, 32'h0000_0100);
		wr(ADDR_ACC, 32'h0000_0011);
		wr(ADDR_INSTR, 32'h0000_e205);
		repeat (4) @(posedge pclk);
		apb(1'b1, ADDR_ACC, 32'h0000_0099);
		chk(e, 1'b1);
		repeat (12) @(posedge pclk);
		rdc(ADDR_ACC, 32'h0000_0011);
		rdc(ADDR_PC, 32'h0000_010c);
		$display("test busy refusal done");

		// an opcode outside the set runs as a plain one-cycle step
		exe(16'hffff, 4);
		rdc(ADDR_STATE, 32'h03ff_0002);
		rdc(ADDR_PC, 32'h0000_010e);
		rdc(ADDR_STATUS, 32'h0000_001f);
		$display("test unknown opcode done");
		test_done;
	end
endmodule
